// File: rtl/sai_port.sv
// serial audio input port: receivers, merge, shared fifo, dma requests

// What this block does
// (R1) Eight receive channels, each with own bit clock, sync and data.
// (R2) All channel words merge into one shared fifo, eight 36-bit entries (word, side, channel).
// (R3) Every frame is 64 bits, split into left and right 32-bit words.
// (R4) Each channel accepts i2s, left-justified or right-justified framing.
// (R5) One sync period carries one pair, written as two half-frame words.
// (R6) Widths: 24/32 for i2s and lj; 24/20/18/16 for rj.
// (R7) Received words leave for memory by dma with no core work.
// (R8) Each channel has its own dma request, separate from other ports.
// (R9) Optionally seven serial channels plus one 20-bit parallel capture.
// (R10) A word arriving at a full fifo sets sticky overflow, is dropped.
module sai_port #(
    parameter int CH_NUM = sai_pkg::CH_NUM,
    parameter int FIFO_DEPTH = sai_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [CH_NUM-1:0] bitClk,
    input wire logic [CH_NUM-1:0] frameSync,
    input wire logic [CH_NUM-1:0] serData,
    input wire logic [sai_pkg::PAR_W-1:0] parData,
    input wire logic parMode,
    input wire logic [2*CH_NUM-1:0] chanFmt,
    input wire logic [3*CH_NUM-1:0] chanWidth,
    output logic [31:0] outData,
    output logic [$clog2(CH_NUM)-1:0] outChan,
    output logic outLeft,
    output logic outValid,
    input wire logic outReady,
    output logic [CH_NUM-1:0] dmaReq,
    output logic ovflFlag,
    input wire logic ovflClr,
    output logic [$clog2(FIFO_DEPTH):0] fifoLevel
);
    localparam int CHAN_W = $clog2(CH_NUM);
    localparam int PTR_W = $clog2(FIFO_DEPTH);
    localparam int ENT_W = sai_pkg::WORD_W + 1 + CHAN_W;
    localparam logic [PTR_W:0] FULL_LVL = (PTR_W + 1)'(FIFO_DEPTH);
    localparam logic [CHAN_W-1:0] LAST_CH = CHAN_W'(CH_NUM - 1);
    localparam logic [CH_NUM-1:0] ONE_HOT0 = CH_NUM'(1);

    // ************************************************************
    // receivers on their own bit clocks
    // ************************************************************
    logic [31:0] laneWord [CH_NUM];
    logic [CH_NUM-1:0] laneLeft;
    logic [CH_NUM-1:0] laneToggle;

    genvar gi;
    generate
        for (gi = 0; gi < CH_NUM; gi++) begin : g_lane
            sai_lane_if lif ();
            logic parEn;
            logic [sai_pkg::CFG_W-1:0] laneCfg;

            // only the top channel can become the parallel capture
            assign parEn = (gi == CH_NUM - 1) ? parMode : 1'b0; // [R9]
            assign laneCfg = {chanFmt[2*gi +: 2], chanWidth[3*gi +: 3],
                parEn};

            sai_lane_rx u_rx ( // [R1]
                .sclk(bitClk[gi]),
                .rstn(rstn),
                .fs(frameSync[gi]),
                .sd(serData[gi]),
                .cfg(laneCfg),
                .parData(parData),
                .lif(lif)
            );

            assign laneWord[gi] = lif.word;
            assign laneLeft[gi] = lif.left;
            assign laneToggle[gi] = lif.toggle;
        end
    endgenerate

    // ************************************************************
    // word events crossing into the reference clock domain
    // ************************************************************
    logic [CH_NUM-1:0] togS1;
    logic [CH_NUM-1:0] togS2;
    logic [CH_NUM-1:0] togSeen;
    logic [CH_NUM-1:0] newWord;

    // toggle synchroniser; the word stays put for a whole half frame
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            togS1 <= '0;
            togS2 <= '0;
            togSeen <= '0;
        end else begin
            togS1 <= laneToggle;
            togS2 <= togS1;
            togSeen <= togS2;
        end
    end

    assign newWord = togS2 ^ togSeen;

    // ************************************************************
    // per-channel holding words and pending flags
    // ************************************************************
    logic [31:0] holdWord [CH_NUM];
    logic [CH_NUM-1:0] holdLeft;
    logic [CH_NUM-1:0] pend;
    logic [CH_NUM-1:0] grantVec;
    logic [CH_NUM-1:0] next_pend;

    // a fresh word wins over the clear of its own grant
    assign next_pend = newWord | (pend & ~grantVec); // [R5]

    generate
        for (gi = 0; gi < CH_NUM; gi++) begin : g_hold
            // copy the stable lane word once its event has crossed
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    holdWord[gi] <= '0;
                    holdLeft[gi] <= 1'b0;
                end else if (newWord[gi]) begin
                    holdWord[gi] <= laneWord[gi];
                    holdLeft[gi] <= laneLeft[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pend <= '0;
        end else begin
            pend <= next_pend;
        end
    end

    // ************************************************************
    // round-robin merge of all channels
    // ************************************************************
    logic [CHAN_W-1:0] rrPtr;
    logic [CHAN_W-1:0] cand;
    logic [CHAN_W-1:0] grantIdx;
    logic grantHit;

    // scan from the channel after the last winner, nearest one wins
    always_comb begin
        grantHit = 1'b0;
        grantIdx = '0;
        cand = '0;
        for (int k = CH_NUM; k >= 1; k--) begin
            cand = CHAN_W'((int'(rrPtr) + k) % CH_NUM); // [R2]
            if (pend[cand]) begin
                grantHit = 1'b1;
                grantIdx = cand;
            end
        end
    end

    assign grantVec = grantHit ? (ONE_HOT0 << grantIdx) : '0;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rrPtr <= LAST_CH;
        end else if (grantHit) begin
            rrPtr <= grantIdx;
        end
    end

    // ************************************************************
    // shared fifo control
    // ************************************************************
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W:0] count;
    logic [PTR_W:0] next_count;
    logic full;
    logic push;
    logic pop;
    logic drop;
    logic stale;
    logic next_stale;
    logic [ENT_W-1:0] wrEntry;
    logic [ENT_W-1:0] rdEntry;

    assign full = count == FULL_LVL;
    assign push = grantHit && !full; // [R2]
    assign drop = grantHit && full; // new word discarded [R10]
    assign pop = outValid && outReady; // [R7]
    assign wrEntry = {grantIdx, holdLeft[grantIdx], holdWord[grantIdx]};
    assign next_count = count + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
    // read register lags a pointer move or a write to the head slot
    assign next_stale = pop || (push && wrPtr == rdPtr);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            stale <= 1'b0;
        end else begin
            wrPtr <= push ? PTR_W'(wrPtr + 1'b1) : wrPtr;
            rdPtr <= pop ? PTR_W'(rdPtr + 1'b1) : rdPtr;
            count <= next_count;
            stale <= next_stale;
        end
    end

    sai_fifo_mem #(
        .W(ENT_W),
        .DEPTH(FIFO_DEPTH),
        .AW(PTR_W)
    ) u_mem (
        .clk(ref_clk),
        .rstn(rstn),
        .wrEn(push),
        .wrAddr(wrPtr),
        .wrData(wrEntry),
        .rdAddr(rdPtr),
        .rdData(rdEntry)
    );

    // ************************************************************
    // head of fifo toward dma
    // ************************************************************
    assign outValid = (count != '0) && !stale;
    assign outData = rdEntry[31:0];
    assign outLeft = rdEntry[sai_pkg::WORD_W];
    assign outChan = rdEntry[ENT_W-1 -: CHAN_W];
    assign fifoLevel = count;

    // one request line per channel, raised for its own head word
    generate
        for (gi = 0; gi < CH_NUM; gi++) begin : g_dma
            assign dmaReq[gi] = outValid && outChan == CHAN_W'(gi); // [R8]
        end
    endgenerate

    // ************************************************************
    // sticky overflow status
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ovflFlag <= 1'b0;
        end else begin
            ovflFlag <= drop | (ovflFlag & ~ovflClr); // set wins [R10]
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_LEVEL_BOUNDED: assert property ( // [R2]
        @(posedge ref_clk) disable iff (!rstn)
        count <= FULL_LVL)
    else $error("fifo level beyond its depth");

    AST_PUSH_RAISES_LEVEL: assert property ( // [R2]
        @(posedge ref_clk) disable iff (!rstn)
        (push && !pop) |=> count == $past(count) + 1'b1)
    else $error("accepted word did not raise the fifo level");

    AST_POP_LOWERS_LEVEL: assert property ( // [R7]
        @(posedge ref_clk) disable iff (!rstn)
        (pop && !push) |=> count == $past(count) - 1'b1)
    else $error("taken word did not lower the fifo level");

    AST_WORD_SERVED: assert property ( // [R5]
        @(posedge ref_clk) disable iff (!rstn)
        newWord[0] |-> ##[0:8] (grantHit && grantIdx == '0))
    else $error("channel word not merged within a round");

    AST_DROP_SETS_FLAG: assert property ( // [R10]
        @(posedge ref_clk) disable iff (!rstn)
        drop |=> ovflFlag)
    else $error("overflow flag not set on dropped word");

    AST_DROP_KEEPS_LEVEL: assert property ( // [R10]
        @(posedge ref_clk) disable iff (!rstn)
        (drop && !pop) |=> (count == FULL_LVL && $stable(wrPtr)))
    else $error("dropped word changed the fifo");

    AST_FLAG_STICKY: assert property ( // [R10]
        @(posedge ref_clk) disable iff (!rstn)
        (ovflFlag && !ovflClr) |=> ovflFlag)
    else $error("overflow flag fell without a clear");

    AST_FLAG_CLEARS: assert property ( // [R10]
        @(posedge ref_clk) disable iff (!rstn)
        (ovflClr && !drop) |=> !ovflFlag)
    else $error("overflow flag not cleared");

    AST_HEAD_READY: assert property ( // [R7]
        @(posedge ref_clk) disable iff (!rstn)
        (push && count == '0) |=> !outValid ##1 outValid)
    else $error("first word not offered two cycles after write");

    AST_DMA_MATCHES_HEAD: assert property ( // [R8]
        @(posedge ref_clk) disable iff (!rstn)
        outValid |-> (dmaReq == (ONE_HOT0 << outChan)))
    else $error("dma request does not match head channel");

    AST_DMA_IDLE: assert property ( // [R8]
        @(posedge ref_clk) disable iff (!rstn)
        !outValid |-> dmaReq == '0)
    else $error("dma request raised with empty head");
endmodule

// File: rtl/sai_pkg.sv
// shared constants and types of the serial audio input port
package sai_pkg;

    // ************************************************************
    // port geometry
    // ************************************************************
    localparam int CH_NUM = 8;          // serial receive channels
    localparam int FIFO_DEPTH = 8;      // shared fifo entries
    localparam int WORD_W = 32;         // fifo word width
    localparam int FRAME_BITS = 64;     // one left/right frame
    localparam int HALF_BITS = FRAME_BITS / 2;
    localparam int PAR_W = 20;          // parallel capture width
    localparam int PAR_PAD = WORD_W - PAR_W;
    localparam int CFG_W = 6;           // format, width code, parallel

    // ************************************************************
    // framing formats
    // ************************************************************
    typedef enum logic [1:0] {
        SAI_FMT_I2S = 2'b00,
        SAI_FMT_LJ = 2'b01,
        SAI_FMT_RJ = 2'b10
    } sai_fmt_t;

    // ************************************************************
    // sample width codes and their bit counts
    // ************************************************************
    localparam logic [2:0] SAI_WC_32 = 3'h0;
    localparam logic [2:0] SAI_WC_24 = 3'h1;
    localparam logic [2:0] SAI_WC_20 = 3'h2;
    localparam logic [2:0] SAI_WC_18 = 3'h3;
    localparam logic [2:0] SAI_WC_16 = 3'h4;
    localparam logic [5:0] SAI_BITS_32 = 6'h20;
    localparam logic [5:0] SAI_BITS_24 = 6'h18;
    localparam logic [5:0] SAI_BITS_20 = 6'h14;
    localparam logic [5:0] SAI_BITS_18 = 6'h12;
    localparam logic [5:0] SAI_BITS_16 = 6'h10;
    localparam logic [5:0] SAI_HALF = 6'h20;
    localparam logic [31:0] SAI_ALL_ONES = 32'hffff_ffff;

endpackage

// File: rtl/sai_lane_if.sv
// carrier between one link-side receiver and the core
interface sai_lane_if;
    logic [31:0] word;      // last finished half-frame word
    logic left;             // word holds the left sample
    logic toggle;           // flips once per finished word

    modport lane (
        output word,
        output left,
        output toggle
    );
    modport core (
        input word,
        input left,
        input toggle
    );
endinterface

// File: rtl/sai_fifo_mem.sv
// storage array of the shared fifo, read data from a register
module sai_fifo_mem #(
    parameter int W = 36,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [W-1:0] wrData,
    input wire logic [AW-1:0] rdAddr,
    output logic [W-1:0] rdData
);
    logic [W-1:0] mem [DEPTH];

    // write port
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // registered read port, one cycle behind the address
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdData <= '0;
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule

// File: rtl/sai_lane_rx.sv
// one serial receiver running on its own bit clock
module sai_lane_rx (
    input wire logic sclk,
    input wire logic rstn,
    input wire logic fs,
    input wire logic sd,
    input wire logic [sai_pkg::CFG_W-1:0] cfg,
    input wire logic [sai_pkg::PAR_W-1:0] parData,
    sai_lane_if.lane lif
);
    // ************************************************************
    // configuration crossing into the bit clock domain
    // ************************************************************
    logic [sai_pkg::CFG_W-1:0] cfgS1;
    logic [sai_pkg::CFG_W-1:0] cfgS2;

    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            cfgS1 <= '0;
            cfgS2 <= '0;
        end else begin
            cfgS1 <= cfg;
            cfgS2 <= cfgS1;
        end
    end

    // ************************************************************
    // decode of format and width
    // ************************************************************
    logic [1:0] fmtCode;
    logic [2:0] widthCode;
    logic parOn;
    logic isI2s;
    logic isRj;
    logic [5:0] widthBits;
    logic [4:0] shamt;
    logic [31:0] mask;

    assign fmtCode = cfgS2[5:4];
    assign widthCode = cfgS2[3:1];
    assign parOn = cfgS2[0];
    assign isRj = fmtCode == sai_pkg::SAI_FMT_RJ;
    assign isI2s = !isRj && fmtCode != sai_pkg::SAI_FMT_LJ; // code 11 as i2s

    // width code to bit count; spare codes fall back to 32 bits
    always_comb begin
        unique case (widthCode)
            sai_pkg::SAI_WC_32: widthBits = sai_pkg::SAI_BITS_32;
            sai_pkg::SAI_WC_24: widthBits = sai_pkg::SAI_BITS_24;
            sai_pkg::SAI_WC_20: widthBits = sai_pkg::SAI_BITS_20;
            sai_pkg::SAI_WC_18: widthBits = sai_pkg::SAI_BITS_18;
            sai_pkg::SAI_WC_16: widthBits = sai_pkg::SAI_BITS_16;
            default: widthBits = sai_pkg::SAI_BITS_32;
        endcase
    end

    assign shamt = 5'(sai_pkg::SAI_HALF - widthBits); // [R6]
    assign mask = sai_pkg::SAI_ALL_ONES << shamt;

    // ************************************************************
    // shifting and half-frame detection
    // ************************************************************
    logic fsPrev;
    logic fsArmed;
    logic [31:0] shiftReg;
    logic i2sDue;
    logic i2sLeft;
    logic fsEdge;
    logic serDone;
    logic serLeft;
    logic wordDone;
    logic [31:0] serWord;
    logic [31:0] next_word;
    logic next_left;

    // the first edge after reset only learns the sync level, no false edge
    assign fsEdge = fsArmed && (fs != fsPrev); // half frame ends [R5]
    // i2s data lags the sync by one bit, so its half closes one edge late
    assign serDone = isI2s ? i2sDue : fsEdge; // [R4]
    assign serLeft = isI2s ? i2sLeft : fsPrev; // [R4]
    // msb-first words, left-aligned; rj samples sit at the half's end
    assign serWord = isRj ? (shiftReg << shamt) : (shiftReg & mask); // [R6]
    // parallel capture takes a word on each edge with the strobe high
    assign wordDone = parOn ? fs : serDone; // [R9]
    assign next_word = parOn ? {parData, sai_pkg::PAR_PAD'(0)} : serWord;
    assign next_left = parOn ? 1'b1 : serLeft;

    // shift register and sync history
    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            shiftReg <= '0;
            fsPrev <= 1'b0;
            fsArmed <= 1'b0;
            i2sDue <= 1'b0;
            i2sLeft <= 1'b0;
        end else begin
            shiftReg <= {shiftReg[30:0], sd}; // [R3]
            fsPrev <= fs;
            fsArmed <= 1'b1;
            i2sDue <= isI2s && fsEdge && !parOn;
            i2sLeft <= !fsPrev; // i2s left sample rides on sync low
        end
    end

    // finished word, announced by a toggle toward the core
    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            lif.word <= '0;
            lif.left <= 1'b0;
            lif.toggle <= 1'b0;
        end else if (wordDone) begin
            lif.word <= next_word; // [R3]
            lif.left <= next_left;
            lif.toggle <= ~lif.toggle;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_LJ_WORD_AT_EDGE: assert property ( // [R4]
        @(posedge sclk) disable iff (!rstn)
        (fsEdge && !parOn && !isI2s) |=> $changed(lif.toggle))
    else $error("left/right-justified word not closed at sync edge");

    AST_I2S_ONE_BIT_LATE: assert property ( // [R4]
        @(posedge sclk) disable iff (!rstn)
        (fsEdge && !parOn && isI2s && $stable(cfgS2))
            |=> $stable(lif.toggle) ##1 $changed(lif.toggle))
    else $error("i2s word not closed one bit after sync edge");

    AST_RJ_TAIL_ZERO: assert property ( // [R6]
        @(posedge sclk) disable iff (!rstn)
        (serDone && isRj && !parOn)
            |=> (lif.word & ~$past(mask)) == 32'h0)
    else $error("right-justified word not shifted to the top");

    AST_PAR_CAPTURE: assert property ( // [R9]
        @(posedge sclk) disable iff (!rstn)
        (parOn && fs)
            |=> lif.word == {$past(parData), sai_pkg::PAR_PAD'(0)})
    else $error("parallel word not captured on strobe");
endmodule

// File: bench/sai_src_model.sv
// behavioural audio source that drives one serial receive channel
module sai_src_model (
    input wire logic go,
    input wire logic [1:0] fmt,
    input wire logic [63:0] frame,
    output logic sclk,
    output logic fs,
    output logic sd,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lj;

    // start-up state: clock stands still low, sync low
    initial begin
        sclk = 1'b0;
        fs = 1'b0;
        sd = 1'b0;
        done = 1'b1;
    end

    // one 64-bit frame per rising go, framed by lead-in and closing edges
    always @(posedge go) begin
        done = 1'b0;
        lj = (fmt == sai_pkg::SAI_FMT_LJ) || (fmt == sai_pkg::SAI_FMT_RJ);
        #7;
        for (int t = -4; t < 66; t++) begin
            // first half on the left level: high for lj and rj, low for i2s
            fs = (t >= 32 && t < 64) ? ~lj : lj; // half frame per level
            if (lj) begin
                sd = (t >= 0 && t < 64) ? frame[63-t] : ~sd; // msb first
            end else begin
                sd = (t >= 1 && t < 65) ? frame[64-t] : ~sd; // one bit late
            end
            #15 sclk = 1'b1;
            #15 sclk = 1'b0;
        end
        sd = ~sd; // released data line does not keep its level
        done = 1'b1;
    end
endmodule

// File: bench/tb_sai_port.sv
// self-checking bench of the serial audio input port
module tb_sai_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic outReady = 1'b0;
    logic ovflClr = 1'b0;
    logic parMode = 1'b0;
    logic pClk = 1'b0;
    logic pFs = 1'b1;
    logic [19:0] parData = 20'h0;
    logic [7:0] go = 8'h0;
    logic [63:0] frm [8];
    wire [7:0] mClk, mFs, mSd, mDone;
    logic [7:0] bitClk, frameSync, dmaReq;
    logic [15:0] chanFmt = 16'haa41; // lj, i2s, i2s, lj, then four rj
    logic [23:0] chanWidth = 24'h8d1240; // 32,32,24,24,24,20,18,16
    logic [31:0] outData;
    logic [2:0] outChan;
    logic [3:0] fifoLevel;
    logic outLeft, outValid, ovflFlag;
    int num_errors = 0;
    int compares = 0;

    // core clock, 10 ns period
    always #5 ref_clk = ~ref_clk;

    // channel 7 pins come from the bench while in parallel capture
    assign bitClk = {parMode ? pClk : mClk[7], mClk[6:0]};
    assign frameSync = {parMode ? pFs : mFs[7], mFs[6:0]};

    // one audio source per channel
    for (genvar g = 0; g < 8; g++) begin : gsrc
        sai_src_model sai_src_model_i (.go(go[g]), .fmt(chanFmt[2*g +: 2]),
            .frame(frm[g]), .sclk(mClk[g]), .fs(mFs[g]), .sd(mSd[g]),
            .done(mDone[g]));
    end

    sai_port sai_port_i (.ref_clk(ref_clk), .rstn(rstn), .bitClk(bitClk),
        .frameSync(frameSync), .serData(mSd), .parData(parData),
        .parMode(parMode), .chanFmt(chanFmt), .chanWidth(chanWidth),
        .outData(outData), .outChan(outChan), .outLeft(outLeft),
        .outValid(outValid), .outReady(outReady), .dmaReq(dmaReq),
        .ovflFlag(ovflFlag), .ovflClr(ovflClr), .fifoLevel(fifoLevel));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("compares=%0d mismatches=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // expected fifo word: sample left-aligned, lower bits zero
    function automatic logic [31:0] exp_word(input int ch,
            input logic [31:0] w);
        logic [5:0] b;
        case (chanWidth[3*ch +: 3])
            sai_pkg::SAI_WC_24: b = sai_pkg::SAI_BITS_24;
            sai_pkg::SAI_WC_20: b = sai_pkg::SAI_BITS_20;
            sai_pkg::SAI_WC_18: b = sai_pkg::SAI_BITS_18;
            sai_pkg::SAI_WC_16: b = sai_pkg::SAI_BITS_16;
            default: b = sai_pkg::SAI_BITS_32;
        endcase
        if (chanFmt[2*ch +: 2] == sai_pkg::SAI_FMT_RJ) begin
            return w << (sai_pkg::SAI_HALF - b);
        end
        return w & ~(sai_pkg::SAI_ALL_ONES >> b);
    endfunction

    // start frames on the masked channels and wait for all sources idle
    task automatic send(input logic [7:0] m);
        int n;
        n = 0;
        go = m;
        @(negedge ref_clk);
        go = 8'h0;
        while (mDone !== 8'hff) begin
            @(negedge ref_clk);
            n++;
            if (n > 500) begin
                num_errors++;
                report_and_stop();
            end
        end
    endtask

    // wait for a head word, take it, leave the stale cycle after the pop
    task automatic pop(output logic [31:0] d, output logic [2:0] c,
            output logic l, output logic [7:0] r);
        int n;
        n = 0;
        while (outValid !== 1'b1) begin
            @(negedge ref_clk);
            n++;
            if (n > 500) begin
                num_errors++;
                report_and_stop();
            end
        end
        d = outData;
        c = outChan;
        l = outLeft;
        r = dmaReq;
        outReady = 1'b1;
        @(negedge ref_clk);
        outReady = 1'b0;
        @(negedge ref_clk);
    endtask

    // empty the fifo and clear the sticky flag
    task automatic flush;
        outReady = 1'b1;
        repeat (40) @(negedge ref_clk);
        outReady = 1'b0;
        ovflClr = 1'b1;
        @(negedge ref_clk);
        ovflClr = 1'b0;
        @(negedge ref_clk);
    endtask

    // one edge of the parallel capture clock, 30 ns
    task automatic pedge(input logic f);
        #2 pFs = f;
        #16 pClk = 1'b1;
        #12 pClk = 1'b0;
    endtask

    // every channel alone: format, width, left then right word
    task automatic t_format;
        logic [31:0] w [2];
        logic [31:0] d;
        logic [2:0] c;
        logic l;
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            w[0] = 32'h9e3779b9 ^ 32'(i);
            w[1] = 32'h6a09e667 + 32'(i);
            frm[i] = {w[0], w[1]};
            send(8'h1 << i);
            for (int k = 0; k < 2; k++) begin
                pop(d, c, l, r);
                chk(32'(c), i);
                chk(32'(l), 32'(k == 0));
                chk(d, exp_word(i, w[k]));
                chk(32'(r), 32'(8'h1 << i));
            end
            chk(32'(fifoLevel), 0);
        end
        $display("test formats done");
    endtask

    // all channels at once into a stalled fifo: merge and overflow
    task automatic t_merge;
        logic [31:0] d;
        logic [2:0] c;
        logic l;
        logic [7:0] r, seen;
        seen = 8'h0;
        for (int i = 0; i < 8; i++) begin
            frm[i] = {32'hc0ffee00 | 32'(i), 32'h0};
        end
        send(8'hff);
        repeat (40) @(negedge ref_clk);
        chk(32'(fifoLevel), sai_pkg::FIFO_DEPTH);
        chk(32'(ovflFlag), 1);
        for (int k = 0; k < 8; k++) begin
            pop(d, c, l, r);
            seen[c] = 1'b1;
            chk(32'(l), 1);
            chk(d, exp_word(c, 32'hc0ffee00 | 32'(c)));
        end
        chk(32'(seen), 32'hff);
        chk(32'(fifoLevel), 0);
        chk(32'(ovflFlag), 1);
        ovflClr = 1'b1;
        @(negedge ref_clk);
        ovflClr = 1'b0;
        @(negedge ref_clk);
        chk(32'(ovflFlag), 0);
        $display("test merge done");
    endtask

    // channel 7 as a 20-bit parallel capture
    task automatic t_par;
        logic [31:0] d;
        logic [2:0] c;
        logic l;
        logic [7:0] r;
        parMode = 1'b1;
        pedge(1'b1);
        pedge(1'b1);
        pedge(1'b0);
        pedge(1'b0);
        flush();
        parData = 20'habcde;
        pedge(1'b1);
        pedge(1'b0);
        pop(d, c, l, r);
        chk(d, {20'habcde, 12'h0});
        chk(32'(c), 7);
        chk(32'(r), 32'h80);
        chk(32'(l), 1);
        $display("test parallel done");
    endtask

    // reset with the lanes clocked, then the scenarios
    initial begin
        for (int i = 0; i < 8; i++) begin
            frm[i] = 64'h0;
        end
        repeat (2) @(negedge ref_clk);
        go = 8'hff;
        repeat (8) @(negedge ref_clk);
        chk(32'(outValid), 0);
        chk(32'(dmaReq), 0);
        chk(32'(ovflFlag), 0);
        chk(32'(fifoLevel), 0);
        rstn = 1'b1;
        send(8'h0);
        flush();
        $display("test reset done");
        t_format();
        t_merge();
        t_par();
        report_and_stop();
    end
endmodule
